// ### dpra_defines.svh
/*
 * Timing constants for the dual-port RAM port controller.
 * Assumes a 40 MHz controller clock (25 ns period).
 */
`ifndef DPRA_DEFINES_SVH
`define DPRA_DEFINES_SVH

// ----------------------------------------------------------------
// Clock and device timing
// ----------------------------------------------------------------
`define DPRA_CLK_PS 25000
`define DPRA_T_SETUP_PS 15000
`define DPRA_T_PULSE_PS 12000
`define DPRA_T_ACCESS_PS 15000
`define DPRA_T_WRITE_HOLD_PS 13000
`define DPRA_T_TOKEN_W2R_PS 5000
`define DPRA_T_TOKEN_PULSE_PS 10000
`define DPRA_T_BUSY_PS 15000
// Three sync flops plus the filtered flag before busy is seen
`define DPRA_SYNC_LAG 4
// Least times round up, never below one cycle
`define DPRA_CYC(t) (((t) + `DPRA_CLK_PS - 1) / `DPRA_CLK_PS)
`define DPRA_PULSE_CYC 4'(`DPRA_CYC(`DPRA_T_PULSE_PS))
`define DPRA_ACCESS_CYC 4'(`DPRA_CYC(`DPRA_T_ACCESS_PS) + 1)
`define DPRA_HOLD_CYC 4'(`DPRA_CYC(`DPRA_T_WRITE_HOLD_PS))
`define DPRA_W2R_CYC 4'(`DPRA_CYC(`DPRA_T_TOKEN_W2R_PS))
`define DPRA_TOKPULSE_CYC 4'(`DPRA_CYC(`DPRA_T_TOKEN_PULSE_PS))
`define DPRA_BUSY_SEE_CYC 4'(`DPRA_CYC(`DPRA_T_BUSY_PS) + `DPRA_SYNC_LAG)
`define DPRA_BUSY_CAP 8'h0_0ff
`define DPRA_ALL_LANES 4'h0
`define DPRA_NO_LANES 4'hf
`define DPRA_ONE 4'h1
`define DPRA_ZERO4 4'h0

`endif

// ### dpra_pkg.sv
/*
 * Types for the dual-port RAM port controller.
 * Assumes dpra_defines.svh is compiled alongside.
 */
package dpra_pkg;
  // ----------------------------------------------------------------
  // Commands and states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DPRA_CMD_RD,
    DPRA_CMD_WR,
    DPRA_CMD_TOK_GET,
    DPRA_CMD_TOK_REL
  } dpra_cmd_t;

  typedef enum logic [2:0] {
    DPRA_ST_IDLE,
    DPRA_ST_SETUP,
    DPRA_ST_STROBE,
    DPRA_ST_BUSYWAIT,
    DPRA_ST_HOLD,
    DPRA_ST_GAP,
    DPRA_ST_TOKRD
  } dpra_state_t;

  // Request from the user side
  typedef struct packed {
    dpra_cmd_t cmd;
    logic [14:0] addr;
    logic [35:0] wdata;
    logic [3:0] lanes_n;
    logic [2:0] token;
  } dpra_req_t;

  // Pins toward the memory port
  typedef struct packed {
    logic [14:0] addr;
    logic chip_select_low_active;
    logic chip_select_high_active;
    logic write_n;
    logic out_enable_n;
    logic token_select_n;
    logic [3:0] byte_lane_select_n;
    logic [35:0] dq_out;
    logic dq_oe;
  } dpra_pins_t;

  // Whole controller state
  typedef struct packed {
    dpra_state_t st;
    dpra_req_t req;
    dpra_pins_t pins;
    logic [3:0] cnt;
    logic [7:0] busy_cnt;
    logic ready;
    logic done;
    logic [35:0] rdata;
    logic granted;
    logic [2:0] busy_sync;
    logic busy_seen;
    logic [2:0] int_sync;
    logic int_seen;
  } dpra_ctl_t;
endpackage : dpra_pkg

// ### dpra_host.sv
/*
 * Controller for one port of an asynchronous dual-port static RAM:
 * memory read/write with byte lanes and token (shared latch) get/release.
 * Assumes the device pins are wired to the *_o/_i ports and the board
 * resolves the data bus from pins_o.dq_oe. Busy and interrupt are async pins.
 */
// Operation
// - Write strobe stays high during reads.
// - Every token read uses its own select.
// - Write strobe high while addresses change.
// - Never drive data while device reads out.
// - Token request writes zero on bit 0.
// - Chip enables stay inactive through token sequence.
// - Keep write low after busy releases.
// - Wait before reading back a token.
// - Token update strobe low long enough.
// - Memory and token selects are exclusive.
`include "dpra_defines.svh"

module dpra_host
  import dpra_pkg::*;
(
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic req_valid_i,
  input wire dpra_req_t req_i,
  output logic req_ready_o,
  output logic done_o,
  output logic [35:0] rdata_o,
  output logic granted_o,
  output logic mailbox_o,
  output dpra_pins_t pins_o,
  input wire logic [35:0] dq_i,
  input wire logic busy_n_i,
  input wire logic int_n_i
);
  dpra_ctl_t s_r;
  dpra_ctl_t s_nxt;
  logic busy_now;
  logic is_tok;
  logic is_wr;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Third and second stages must agree before a pin change counts
  // Filtered flag, so a glitch cannot stall or release a write alone
  assign busy_now = s_r.busy_seen;
  assign is_tok = s_r.req.cmd inside {DPRA_CMD_TOK_GET, DPRA_CMD_TOK_REL};
  assign is_wr = s_r.req.cmd != DPRA_CMD_RD;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.busy_sync = {s_r.busy_sync[1:0], busy_n_i};
    s_nxt.int_sync = {s_r.int_sync[1:0], int_n_i};
    if (s_r.int_sync[2] == s_r.int_sync[1]) begin
      s_nxt.int_seen = ~s_r.int_sync[2];
    end
    // Busy filter, same agreement rule as the mailbox pin
    if (s_r.busy_sync[2] == s_r.busy_sync[1]) begin
      s_nxt.busy_seen = ~s_r.busy_sync[2];
    end
    case (s_r.st)
      DPRA_ST_IDLE: begin
        s_nxt.ready = 1'b1;
        if (req_valid_i && s_r.ready) begin
          // Address settles with strobe high and port deselected
          s_nxt.ready = 1'b0;
          s_nxt.req = req_i;
          // Token cycles get their latch address now, not under the strobe
          s_nxt.pins.addr = (req_i.cmd == DPRA_CMD_TOK_GET ||
                             req_i.cmd == DPRA_CMD_TOK_REL) ?
                            {12'h000, req_i.token} : req_i.addr;
          s_nxt.pins.write_n = 1'b1;
          s_nxt.pins.chip_select_low_active = 1'b1;
          s_nxt.pins.chip_select_high_active = 1'b0;
          s_nxt.pins.token_select_n = 1'b1;
          s_nxt.pins.byte_lane_select_n = `DPRA_NO_LANES;
          s_nxt.cnt = `DPRA_ZERO4;
          s_nxt.st = DPRA_ST_SETUP;
        end
      end
      DPRA_ST_SETUP: begin
        // Select and strobe assert in the same cycle; writes keep out_enable_n high so outputs stay off
        // Exclusive selects; token cycle keeps both chip enables off
        if (req_i.cmd == DPRA_CMD_RD || s_r.req.cmd == DPRA_CMD_RD ||
            s_r.req.cmd == DPRA_CMD_WR) begin
          if (!is_tok) begin
            s_nxt.pins.chip_select_low_active = 1'b0;
            s_nxt.pins.chip_select_high_active = 1'b1;
            s_nxt.pins.byte_lane_select_n = is_wr ? s_r.req.lanes_n
                                                  : `DPRA_ALL_LANES;
          end
        end
        if (is_tok) begin
          s_nxt.pins.token_select_n = 1'b0;
        end
        if (is_wr) begin
          // Token get writes 0 on bit 0, release writes 1
          s_nxt.pins.dq_out = is_tok ?
            {35'h0_0000_0000, s_r.req.cmd == DPRA_CMD_TOK_REL}
            : s_r.req.wdata;
          s_nxt.pins.dq_oe = 1'b1;
          s_nxt.pins.out_enable_n = 1'b1;
          s_nxt.pins.write_n = 1'b0;
        end else begin
          s_nxt.pins.out_enable_n = 1'b0;
        end
        s_nxt.cnt = `DPRA_ZERO4;
        s_nxt.st = DPRA_ST_STROBE;
      end
      DPRA_ST_STROBE: begin
        s_nxt.cnt = s_r.cnt + `DPRA_ONE;
        if (is_wr && busy_now && !is_tok) begin
          s_nxt.busy_cnt = 8'h0_000;
          s_nxt.st = DPRA_ST_BUSYWAIT;
        // Memory writes hold the strobe until a busy flag could be seen
        end else if (is_wr && s_r.cnt + `DPRA_ONE >= `DPRA_TOKPULSE_CYC &&
                     s_r.cnt + `DPRA_ONE >= `DPRA_PULSE_CYC &&
                     (is_tok ||
                      s_r.cnt + `DPRA_ONE >= `DPRA_BUSY_SEE_CYC)) begin
          s_nxt.pins.write_n = 1'b1;
          s_nxt.cnt = `DPRA_ZERO4;
          s_nxt.st = DPRA_ST_GAP;
        end else if (!is_wr && s_r.cnt + `DPRA_ONE >= `DPRA_ACCESS_CYC) begin
          s_nxt.rdata = dq_i;
          s_nxt.pins.out_enable_n = 1'b1;
          s_nxt.pins.chip_select_low_active = 1'b1;
          s_nxt.pins.chip_select_high_active = 1'b0;
          s_nxt.pins.byte_lane_select_n = `DPRA_NO_LANES;
          s_nxt.done = 1'b1;
          s_nxt.st = DPRA_ST_IDLE;
        end
      end
      DPRA_ST_BUSYWAIT: begin
        // Capped so a stuck flag cannot hang the port
        s_nxt.busy_cnt = s_r.busy_cnt + 8'h0_001;
        if (!busy_now || s_r.busy_cnt == `DPRA_BUSY_CAP) begin
          s_nxt.cnt = `DPRA_ZERO4;
          s_nxt.st = DPRA_ST_HOLD;
        end
      end
      DPRA_ST_HOLD: begin
        // Strobe held after release so the blocked write lands
        s_nxt.cnt = s_r.cnt + `DPRA_ONE;
        if (s_r.cnt + `DPRA_ONE >= `DPRA_HOLD_CYC) begin
          s_nxt.pins.write_n = 1'b1;
          s_nxt.cnt = `DPRA_ZERO4;
          s_nxt.st = DPRA_ST_GAP;
        end
      end
      DPRA_ST_GAP: begin
        // Deselect so each token read gets its own select cycle
        s_nxt.pins.dq_oe = 1'b0;
        s_nxt.pins.token_select_n = 1'b1;
        s_nxt.pins.chip_select_low_active = 1'b1;
        s_nxt.pins.chip_select_high_active = 1'b0;
        s_nxt.pins.byte_lane_select_n = `DPRA_NO_LANES;
        s_nxt.cnt = s_r.cnt + `DPRA_ONE;
        if (!is_tok) begin
          s_nxt.done = 1'b1;
          s_nxt.st = DPRA_ST_IDLE;
        // One full cycle deselected before the read-back select
        end else if (s_r.pins.token_select_n &&
                     s_r.cnt + `DPRA_ONE >= `DPRA_W2R_CYC) begin
          s_nxt.pins.token_select_n = 1'b0;
          s_nxt.pins.out_enable_n = 1'b0;
          s_nxt.cnt = `DPRA_ZERO4;
          s_nxt.st = DPRA_ST_TOKRD;
        end
      end
      DPRA_ST_TOKRD: begin
        s_nxt.cnt = s_r.cnt + `DPRA_ONE;
        if (s_r.cnt + `DPRA_ONE >= `DPRA_ACCESS_CYC) begin
          s_nxt.granted = ~dq_i[0];
          s_nxt.rdata = dq_i;
          s_nxt.pins.token_select_n = 1'b1;
          s_nxt.pins.out_enable_n = 1'b1;
          s_nxt.done = 1'b1;
          s_nxt.st = DPRA_ST_IDLE;
        end
      end
      default: s_nxt.st = DPRA_ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      s_r <= '0;
      s_r.pins.write_n <= 1'b1;
      s_r.pins.out_enable_n <= 1'b1;
      s_r.pins.token_select_n <= 1'b1;
      s_r.pins.chip_select_low_active <= 1'b1;
      s_r.pins.byte_lane_select_n <= `DPRA_NO_LANES;
      s_r.busy_sync <= 3'h7;
      s_r.int_sync <= 3'h7;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign req_ready_o = s_r.ready;
  assign done_o = s_r.done;
  assign rdata_o = s_r.rdata;
  assign granted_o = s_r.granted;
  assign mailbox_o = s_r.int_seen;
  assign pins_o = s_r.pins;
endmodule : dpra_host

// ### dpra_host_assertions.sv
/* Pin-rule checker for dpra_host.
   Assumes bound to dpra_host, one clock. */
module dpra_host_chk
  import dpra_pkg::*;
(
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic req_valid_i,
  input wire dpra_req_t req_i,
  input wire logic req_ready_o,
  input wire dpra_pins_t pins_o,
  input wire logic busy_n_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Pin rules
  // ----------------------------------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  logic get_r;
  // Remember a token request at the take
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      get_r <= 1'b0;
    end else if (req_valid_i && req_ready_o) begin
      get_r <= req_i.cmd == DPRA_CMD_TOK_GET;
    end
  end
  a_read_wr_high: assert property (
    !pins_o.out_enable_n |-> pins_o.write_n) else $error("strobe in read");
  a_addr_wr_high: assert property (
    $changed(pins_o.addr) |-> pins_o.write_n && $past(pins_o.write_n))
    else $error("addr moved in write");
  a_no_bus_fight: assert property (
    !pins_o.out_enable_n |-> !pins_o.dq_oe) else $error("bus fight");
  a_tok_sel_only: assert property (
    !pins_o.token_select_n |->
    pins_o.chip_select_low_active && !pins_o.chip_select_high_active)
    else $error("chip on in token");
  a_mem_sel_only: assert property (
    !pins_o.chip_select_low_active |-> pins_o.token_select_n)
    else $error("token on in mem");
  a_tok_get_zero: assert property (
    get_r && !pins_o.token_select_n && !pins_o.write_n |->
    pins_o.dq_oe && !pins_o.dq_out[0]) else $error("token bit0 not 0");
  a_tok_own_sel: assert property (
    !pins_o.token_select_n && $fell(pins_o.out_enable_n) |->
    $fell(pins_o.token_select_n)) else $error("token read shares select");
  a_tok_w2r_gap: assert property (
    !pins_o.token_select_n && !pins_o.out_enable_n |-> $past(pins_o.write_n))
    else $error("token read too soon");
  a_tok_pulse_len: assert property (
    $fell(pins_o.token_select_n) |=> !pins_o.token_select_n)
    else $error("token pulse short");
  a_busy_wr_hold: assert property (
    $rose(busy_n_i) && !pins_o.write_n |=> !pins_o.write_n)
    else $error("write cut at busy end");
endmodule : dpra_host_chk

bind dpra_host dpra_host_chk u_chk (.mclk_i, .srst_i, .req_valid_i, .req_i,
  .req_ready_o, .pins_o, .busy_n_i);

// ### dpra_dev_model.sv
/* Behavioural model of one port of the dual-port memory.
   Assumes the other port is summarised by the oth_* inputs. */
module dpra_dev_model
  import dpra_pkg::*;
(
  input wire dpra_pins_t pins_i,
  input wire logic [7:0] oth_tok_i,
  input wire logic [14:0] oth_addr_i,
  input wire logic oth_act_i,
  input wire logic mail_i,
  output logic [35:0] dq_o,
  output logic busy_n_o,
  output logic int_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Storage and pins
  // ----------------------------------------
  logic [35:0] mem [0:32767];
  logic [7:0] own = 8'h00;
  logic [35:0] rd, prev = '0;
  logic msel, drv;
  logic [2:0] t;
  assign t = pins_i.addr[2:0];
  assign msel = !pins_i.chip_select_low_active && pins_i.chip_select_high_active;
  // Write before select keeps outputs off
  assign drv = pins_i.write_n && !pins_i.out_enable_n &&
    (msel || !pins_i.token_select_n);
  assign rd = pins_i.token_select_n ? mem[pins_i.addr] : {35'h0, ~own[t]};
  // Idle bus shows inverse of last value, never a kind constant
  assign dq_o = pins_i.dq_oe ? pins_i.dq_out : drv ? rd : ~prev;
  assign busy_n_o = !(oth_act_i && msel && oth_addr_i == pins_i.addr);
  assign int_n_o = !mail_i;
  always @(negedge drv) prev = rd;
  always @(negedge pins_i.dq_oe) prev = pins_i.dq_out;
  // Commit at write end; busy blocks it
  always @(posedge pins_i.write_n) begin
    if (msel && busy_n_o) begin
      for (int i = 0; i < 4; i++) begin
        if (!pins_i.byte_lane_select_n[i]) mem[pins_i.addr][i*9+:9] = pins_i.dq_out[i*9+:9];
      end
    end
    if (!pins_i.token_select_n) begin
      if (pins_i.dq_out[0]) own[t] = 1'b0;
      else if (!oth_tok_i[t]) own[t] = 1'b1;
    end
  end
endmodule : dpra_dev_model

// ### dpra_host_tb.sv
/* Self-checking bench for dpra_host.
   Assumes dpra_dev_model stands at the pins. */
module dpra_host_tb
  import dpra_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 0, srst_i = 1, req_valid_i = 0, busy_n_i, int_n_i;
  logic oth_act = 0, mail = 0, req_ready_o, done_o, granted_o, mailbox_o;
  logic [7:0] oth_tok = '0;
  logic [35:0] rdata_o, dq_i;
  dpra_req_t req_i = '0;
  dpra_pins_t pins_o;
  int n_errors = 0, tests_run = 0, cyc = 0;
  always #12.5 mclk_i = ~mclk_i;
  dpra_host dut (.mclk_i, .srst_i, .req_valid_i, .req_i, .req_ready_o, .done_o,
    .rdata_o, .granted_o, .mailbox_o, .pins_o, .dq_i, .busy_n_i, .int_n_i);
  dpra_dev_model u_dev (.pins_i(pins_o), .oth_tok_i(oth_tok),
    .oth_addr_i(15'h0123), .oth_act_i(oth_act), .mail_i(mail), .dq_o(dq_i),
    .busy_n_o(busy_n_i), .int_n_o(int_n_i));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input string s, input logic [35:0] g, e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task finish_test;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  // One request, then a bounded wait for done
  task op(input dpra_cmd_t c, input logic [14:0] a, input logic [35:0] d,
    input logic [3:0] l);
    int n;
    req_i <= '{c, a, d, l, a[2:0]};
    req_valid_i <= 1'b1;
    @(posedge mclk_i);
    while (req_ready_o !== 1'b1) @(posedge mclk_i);
    req_valid_i <= 1'b0;
    n = 0;
    do begin @(posedge mclk_i); n++; end while (done_o !== 1'b1 && n < 400);
    if (n >= 400) chk("done", 0, 1);
  endtask : op
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_mem;
    op(DPRA_CMD_WR, 15'h0123, 36'h1_2345_6789, 4'h0);
    op(DPRA_CMD_RD, 15'h0123, '0, 4'h0);
    chk("word", rdata_o, 36'h1_2345_6789);
    op(DPRA_CMD_WR, 15'h0123, 36'hf_ffff_ffff, 4'he);
    op(DPRA_CMD_RD, 15'h0123, '0, 4'h0);
    chk("lane0", rdata_o, 36'h1_2345_67ff);
    $display("test mem done");
  endtask : t_mem
  task t_tok;
    op(DPRA_CMD_TOK_GET, 15'h0003, '0, 4'hf);
    chk("get free", granted_o, 1);
    oth_tok <= 8'h20;
    op(DPRA_CMD_TOK_GET, 15'h0005, '0, 4'hf);
    chk("get held", granted_o, 0);
    op(DPRA_CMD_TOK_REL, 15'h0003, '0, 4'hf);
    chk("release", granted_o, 0);
    $display("test token done");
  endtask : t_tok
  // Contending port leaves after 20 cycles
  task t_busy;
    oth_act <= 1'b1;
    fork
      op(DPRA_CMD_WR, 15'h0123, 36'h0_abcd_0123, 4'h0);
      begin repeat (20) @(posedge mclk_i); oth_act <= 1'b0; end
    join
    op(DPRA_CMD_RD, 15'h0123, '0, 4'h0);
    chk("busy write", rdata_o, 36'h0_abcd_0123);
    $display("test busy done");
  endtask : t_busy
  task t_mail;
    mail <= 1'b1;
    repeat (8) @(posedge mclk_i);
    chk("mail set", mailbox_o, 1);
    mail <= 1'b0;
    repeat (8) @(posedge mclk_i);
    chk("mail clear", mailbox_o, 0);
    $display("test mail done");
  endtask : t_mail
  // Hang guard
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 5000) begin n_errors++; finish_test; end
  end
  initial begin
    repeat (10) @(posedge mclk_i);
    srst_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    t_mem;
    t_tok;
    t_busy;
    t_mail;
    finish_test;
  end
endmodule : dpra_host_tb
